// >>> hw/nfc_pkg.sv
// Purpose: shared constants of the flash controller register front end
// Assumes: one 100 MHz clock, full 32-bit bus addresses
// Notes: timing figures are least times and round up to whole cycles
package nfc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [31:0] NFC_CTRL_ADDR = 32'h40C0_0004;
  localparam logic [31:0] NFC_CMD_ADDR = 32'h40C0_0008;
  localparam logic [31:0] NFC_ADDR_ADDR = 32'h40C0_000C;
  localparam logic [31:0] NFC_DATA_ADDR = 32'h40C0_0010;
  localparam logic [31:0] NFC_EVT_ADDR = 32'h40C0_0030;
  localparam logic [31:0] NFC_PAR_ADDR = 32'h40C0_0034;
  localparam logic [31:0] NFC_CTRL_RESET = 32'h0000_0384;

  localparam logic [2:0] NFC_SEL_NONE = 3'h0;
  localparam logic [2:0] NFC_SEL_CTRL = 3'h1;
  localparam logic [2:0] NFC_SEL_CMD = 3'h2;
  localparam logic [2:0] NFC_SEL_ADDR = 3'h3;
  localparam logic [2:0] NFC_SEL_DATA = 3'h4;
  localparam logic [2:0] NFC_SEL_EVT = 3'h5;
  localparam logic [2:0] NFC_SEL_PAR = 3'h6;

  // ****************************************
  // control register fields
  // ****************************************
  localparam int NFC_LOCK_BIT = 2;
  localparam int NFC_TIGHT_BIT = 3;
  localparam int NFC_PAGE_LSB = 4;
  localparam int NFC_CE_BIT = 7;
  localparam int NFC_INIT_BIT = 8;
  localparam int NFC_MFRZ_BIT = 9;
  localparam int NFC_SFRZ_BIT = 10;
  localparam int NFC_EDGE_BIT = 11;
  localparam int NFC_IEN_LSB = 12;
  localparam int NFC_BUF_LSB = 18;

  typedef enum logic [1:0] {
    NFC_MODE_OFF = 2'h0,
    NFC_MODE_LOAD = 2'h1,
    NFC_MODE_STORE = 2'h2,
    NFC_MODE_SW = 2'h3
  } nfc_mode_type;

  // flash cycle kinds and event bits
  localparam logic [1:0] NFC_K_CMD = 2'h0;
  localparam logic [1:0] NFC_K_ADDR = 2'h1;
  localparam logic [1:0] NFC_K_WR = 2'h2;
  localparam logic [1:0] NFC_K_RD = 2'h3;
  localparam int NFC_EV_RB = 0;
  localparam int NFC_EV_STORE = 1;
  localparam int NFC_EV_LOAD = 2;
  localparam int NFC_EV_BAD = 3;

  // ****************************************
  // timing
  // ****************************************
  localparam int NFC_CLK_NS = 10;
  localparam int NFC_STROBE_LO_NS = 30;
  localparam int NFC_STROBE_HI_NS = 20;
  localparam int NFC_SETTLE_NS = 100;
  localparam logic [3:0] NFC_LO_CYC =
    4'((NFC_STROBE_LO_NS + NFC_CLK_NS - 1) / NFC_CLK_NS);
  localparam logic [3:0] NFC_HI_CYC =
    4'((NFC_STROBE_HI_NS + NFC_CLK_NS - 1) / NFC_CLK_NS);
  localparam logic [3:0] NFC_SETTLE_CYC =
    4'((NFC_SETTLE_NS + NFC_CLK_NS - 1) / NFC_CLK_NS);

endpackage : nfc_pkg

// >>> hw/nfc_ctrl_regs.sv
// Purpose: register front end and cycle engine of a flash controller
// Assumes: ahb-lite single word transfers, buffer read is combinational
// Notes: parity is a plain word xor, not a correcting code
`timescale 1ns/100ps
`default_nettype none
module nfc_ctrl_regs
  import nfc_pkg::*;
#(
  parameter int PAGE_WORDS = 256,
  parameter int ADDR_CYCLES = 4
)(
  // clock and reset
  input wire logic core_clk_i,
  input wire logic reset_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // flash pins
  output logic [15:0] flash_io_o,
  output logic flash_io_oe_o,
  input wire logic [15:0] flash_io_i,
  output logic flash_cle_o,
  output logic flash_ale_o,
  output logic flash_we_n_o,
  output logic flash_re_n_o,
  output logic flash_chip_enable_n_o,
  input wire logic ready_busy_input_i,
  // configuration from outside
  input wire logic hw_chip_enable_ctrl_i,
  // on-chip buffer
  output logic [11:0] buf_addr_o,
  output logic buf_we_o,
  output logic [15:0] buf_wdata_o,
  input wire logic [15:0] buf_rdata_i,
  // interrupt
  output logic irq_o
);

  // ****************************************
  // state
  // ****************************************
  localparam int WW = $clog2(PAGE_WORDS);

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LO = 2'h1,
    ST_HI = 2'h3,
    ST_WAIT = 2'h2
  } nfc_fsm_type;

  typedef enum logic [2:0] {
    PH_SW = 3'h0,
    PH_CMD0 = 3'h1,
    PH_ADDR = 3'h3,
    PH_CMD1 = 3'h2,
    PH_XFER = 3'h6,
    PH_FIN = 3'h7
  } nfc_ph_type;

  typedef struct packed {
    nfc_mode_type mode;
    logic [11:0] bufloc;
    logic [3:0] irq_en;
    logic edge_sel;
    logic spare_frz;
    logic main_frz;
    logic ce_ctrl;
    logic [2:0] page_cnt;
    logic tight;
    logic lock;
    logic [15:0] cmd;
    logic [31:0] addr;
    logic [15:0] data;
    logic [15:0] mpar;
    logic [15:0] spar;
    logic [3:0] pend;
    nfc_fsm_type fsm;
    nfc_ph_type ph;
    logic [1:0] kind;
    logic [3:0] tmr;
    logic [2:0] acnt;
    logic [2:0] pcnt;
    logic [WW-1:0] wcnt;
    logic [11:0] lin;
    logic dph;
    logic dwr;
    logic dbad;
    logic dgo;
    logic [2:0] dsel;
    logic hready;
    logic [31:0] hrdata;
    logic [15:0] io_o;
    logic io_oe;
    logic cle;
    logic ale;
    logic we_n;
    logic re_n;
    logic ce_n;
    logic [11:0] baddr;
    logic bwe;
    logic [15:0] bwdata;
    logic irq;
    logic rb1;
    logic rb2;
    logic rb3;
    logic [15:0] io1;
    logic [15:0] io2;
  } nfc_state_type;

  nfc_state_type s;
  nfc_state_type n;
  logic [2:0] sel;
  logic go;
  logic [1:0] gk;
  logic [15:0] gio;
  logic [3:0] ev;
  logic [3:0] clr;
  logic wr_ctrl;
  logic wr_init;
  logic rb_edge;
  logic upd;
  logic [15:0] word;
  logic load;
  logic [1:0] aidx;
  logic [31:0] rd;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    n = s;
    go = 1'b0;
    gk = NFC_K_CMD;
    gio = 16'h0000;
    ev = 4'h0;
    clr = 4'h0;
    wr_ctrl = 1'b0;
    upd = 1'b0;
    word = 16'h0000;
    load = (s.mode == NFC_MODE_LOAD);
    aidx = (s.acnt > 3'h3) ? 2'h3 : s.acnt[1:0];
    n.rb1 = ready_busy_input_i;
    n.rb2 = s.rb1;
    n.rb3 = s.rb2;
    n.io1 = flash_io_i;
    n.io2 = s.io1;
    n.bwe = 1'b0;
    rb_edge = s.edge_sel ? (s.rb3 & ~s.rb2) : (~s.rb3 & s.rb2);
    ev[NFC_EV_RB] = rb_edge;
    case (haddr_i)
      NFC_CTRL_ADDR: sel = NFC_SEL_CTRL;
      NFC_CMD_ADDR: sel = NFC_SEL_CMD;
      NFC_ADDR_ADDR: sel = NFC_SEL_ADDR;
      NFC_DATA_ADDR: sel = NFC_SEL_DATA;
      NFC_EVT_ADDR: sel = NFC_SEL_EVT;
      NFC_PAR_ADDR: sel = NFC_SEL_PAR;
      default: sel = NFC_SEL_NONE;
    endcase
    case (sel)
      NFC_SEL_CTRL: rd = {4'h0, s.bufloc, s.irq_en, s.edge_sel, s.spare_frz,
        s.main_frz, 1'b0, s.ce_ctrl, s.page_cnt, s.tight, s.lock, s.mode};
      NFC_SEL_CMD: rd = {16'h0000, s.cmd};
      NFC_SEL_ADDR: rd = s.addr;
      NFC_SEL_DATA: rd = {16'h0000, s.data};
      NFC_SEL_EVT: rd = {28'h0000000, s.pend};
      NFC_SEL_PAR: rd = {s.spar, s.mpar};
      default: rd = 32'h0000_0000;
    endcase
    // ****************************************
    // strobe timing and sequence steps
    // ****************************************
    case (s.fsm)
      ST_LO:
      begin
        if (s.tmr == 4'h0)
        begin
          n.fsm = ST_HI;
          n.tmr = NFC_HI_CYC - 4'h1;
          n.we_n = 1'b1;
          n.re_n = 1'b1;
          if (s.kind == NFC_K_RD)
          begin
            n.data = s.io2;
            upd = 1'b1;
            word = s.io2;
            if (s.ph == PH_XFER)
            begin
              n.bwe = 1'b1;
              n.bwdata = s.io2;
            end
          end
        end
        else
          n.tmr = s.tmr - 4'h1;
      end
      ST_HI:
      begin
        if (s.tmr == 4'h0)
        begin
          n.fsm = ST_IDLE;
          n.cle = 1'b0;
          n.ale = 1'b0;
          n.io_oe = 1'b0;
          case (s.ph)
            PH_CMD0:
            begin
              n.ph = PH_ADDR;
              n.acnt = 3'h0;
            end
            PH_ADDR:
            begin
              n.acnt = s.acnt + 3'h1;
              if (s.acnt == 3'(ADDR_CYCLES - 1))
                n.ph = load ? PH_CMD1 : PH_XFER;
            end
            PH_CMD1:
            begin
              n.fsm = ST_WAIT;
              n.tmr = NFC_SETTLE_CYC;
              n.ph = load ? PH_XFER : PH_FIN;
            end
            PH_XFER:
            begin
              n.lin = s.lin + 12'h001;
              n.wcnt = s.wcnt + WW'(1);
              if (s.wcnt == WW'(PAGE_WORDS - 1))
              begin
                n.wcnt = '0;
                if (!load)
                  n.ph = PH_CMD1;
                else if (s.pcnt == s.page_cnt)
                  n.ph = PH_FIN;
                else
                  n.pcnt = s.pcnt + 3'h1;
              end
            end
            default:
            begin
              n.hready = 1'b1;
              n.dgo = 1'b0;
              n.hrdata = {16'h0000, s.data};
            end
          endcase
        end
        else
          n.tmr = s.tmr - 4'h1;
      end
      ST_WAIT:
      begin
        // busy line must settle before ready counts
        if (s.tmr != 4'h0)
          n.tmr = s.tmr - 4'h1;
        else if (s.rb2)
          n.fsm = ST_IDLE;
      end
      default:
      begin
        case (s.ph)
          PH_CMD0:
          begin
            go = 1'b1;
            gio = {8'h00, s.cmd[7:0]};
          end
          PH_ADDR:
          begin
            go = 1'b1;
            gk = NFC_K_ADDR;
            gio = {8'h00, s.addr[{aidx, 3'h0} +: 8]};
          end
          PH_CMD1:
          begin
            go = 1'b1;
            gio = {8'h00, s.cmd[15:8]};
          end
          PH_XFER:
          begin
            go = 1'b1;
            gk = load ? NFC_K_RD : NFC_K_WR;
            gio = buf_rdata_i;
            upd = !load;
            word = buf_rdata_i;
          end
          PH_FIN:
          begin
            n.ph = PH_SW;
            n.ce_ctrl = 1'b1;
            ev[NFC_EV_LOAD] = load;
            ev[NFC_EV_STORE] = !load;
          end
          default:
          begin
            if (s.dph && !s.hready && !s.dgo)
            begin
              go = 1'b1;
              n.dgo = 1'b1;
              case (s.dsel)
                NFC_SEL_CMD: gio = {8'h00, hwdata_i[7:0]};
                NFC_SEL_ADDR:
                begin
                  gk = NFC_K_ADDR;
                  gio = {8'h00, hwdata_i[7:0]};
                end
                default:
                begin
                  gk = s.dwr ? NFC_K_WR : NFC_K_RD;
                  gio = hwdata_i[15:0];
                  upd = s.dwr;
                  word = hwdata_i[15:0];
                end
              endcase
            end
          end
        endcase
      end
    endcase
    if (go)
    begin
      n.fsm = ST_LO;
      n.kind = gk;
      n.tmr = NFC_LO_CYC - 4'h1;
      n.io_o = gio;
      n.io_oe = (gk != NFC_K_RD);
      n.cle = (gk == NFC_K_CMD);
      n.ale = (gk == NFC_K_ADDR);
      n.we_n = (gk == NFC_K_RD);
      n.re_n = (gk != NFC_K_RD);
    end
    // ****************************************
    // bus slave
    // ****************************************
    if (s.dph && s.hready)
    begin
      n.dph = 1'b0;
      if (s.dwr)
      begin
        case (s.dsel)
          NFC_SEL_CTRL: wr_ctrl = 1'b1;
          NFC_SEL_CMD: n.cmd = hwdata_i[15:0];
          NFC_SEL_ADDR: n.addr = hwdata_i;
          NFC_SEL_DATA:
          begin
            if (s.dbad)
              ev[NFC_EV_BAD] = 1'b1;
            else
              n.data = hwdata_i[15:0];
          end
          NFC_SEL_EVT: clr = hwdata_i[3:0];
          default: ;
        endcase
      end
    end
    if (hsel_i && htrans_i[1] && hready_i)
    begin
      n.dph = 1'b1;
      n.dwr = hwrite_i;
      n.dsel = sel;
      n.hrdata = rd;
      // locked program writes are refused without a flash cycle
      n.dbad = hwrite_i && (sel == NFC_SEL_DATA) && (s.mode == NFC_MODE_SW) && s.lock;
      if ((s.mode == NFC_MODE_SW) && !n.dbad && (((hwrite_i && (sel == NFC_SEL_CMD ||
          sel == NFC_SEL_ADDR))) || sel == NFC_SEL_DATA))
        n.hready = 1'b0;
    end
    // ****************************************
    // control register write
    // ****************************************
    wr_init = wr_ctrl && hwdata_i[NFC_INIT_BIT];
    if (wr_ctrl)
    begin
      n.mode = nfc_mode_type'(hwdata_i[1:0]);
      n.lock = hwdata_i[NFC_LOCK_BIT];
      n.tight = s.tight | hwdata_i[NFC_TIGHT_BIT];
      n.page_cnt = hwdata_i[NFC_PAGE_LSB +: 3];
      n.ce_ctrl = hwdata_i[NFC_CE_BIT];
      n.main_frz = hwdata_i[NFC_MFRZ_BIT];
      n.spare_frz = hwdata_i[NFC_SFRZ_BIT];
      n.edge_sel = hwdata_i[NFC_EDGE_BIT];
      n.irq_en = hwdata_i[NFC_IEN_LSB +: 4];
      n.bufloc = {hwdata_i[NFC_BUF_LSB +: 10], 2'h0};
      if ((hwdata_i[1:0] == NFC_MODE_LOAD || hwdata_i[1:0] == NFC_MODE_STORE)
          && s.ph == PH_SW && s.fsm == ST_IDLE)
      begin
        n.ph = PH_CMD0;
        n.lin = 12'h000;
        n.pcnt = 3'h0;
        n.wcnt = '0;
      end
    end
    if (upd)
    begin
      if (s.ph != PH_SW || !s.main_frz)
        n.mpar = s.mpar ^ word;
      else if (!s.spare_frz)
        n.spar = s.spar ^ word;
    end
    if (wr_init)
    begin
      n.mpar = 16'h0000;
      n.spar = 16'h0000;
    end
    case (n.mode)
      NFC_MODE_SW: n.ce_n = n.ce_ctrl & ~(hw_chip_enable_ctrl_i & (n.fsm != ST_IDLE));
      NFC_MODE_LOAD, NFC_MODE_STORE: n.ce_n = (n.ph == PH_SW);
      default: n.ce_n = n.ce_ctrl;
    endcase
    if (s.ph == PH_FIN)
      n.ce_n = 1'b1;
    n.pend = (s.pend & ~clr) | ev;
    n.irq = |(n.pend & n.irq_en);
    n.baddr = 12'(n.bufloc + n.lin);
  end

  always_ff @(posedge core_clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      s <= '0;
      s.lock <= NFC_CTRL_RESET[NFC_LOCK_BIT];
      s.ce_ctrl <= NFC_CTRL_RESET[NFC_CE_BIT];
      s.main_frz <= NFC_CTRL_RESET[NFC_MFRZ_BIT];
      s.spare_frz <= 1'b1;
      // ready line idles high, so no false edge after reset
      s.rb1 <= 1'b1;
      s.rb2 <= 1'b1;
      s.rb3 <= 1'b1;
      s.hready <= 1'b1;
      s.we_n <= 1'b1;
      s.re_n <= 1'b1;
      s.ce_n <= 1'b1;
    end
    else
      s <= n;
  end

  assign hrdata_o = s.hrdata;
  assign hreadyout_o = s.hready;
  assign hresp_o = 1'b0;
  assign flash_io_o = s.io_o;
  assign flash_io_oe_o = s.io_oe;
  assign flash_cle_o = s.cle;
  assign flash_ale_o = s.ale;
  assign flash_we_n_o = s.we_n;
  assign flash_re_n_o = s.re_n;
  assign flash_chip_enable_n_o = s.ce_n;
  assign buf_addr_o = s.baddr;
  assign buf_we_o = s.bwe;
  assign buf_wdata_o = s.bwdata;
  assign irq_o = s.irq;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);

  a_ce_release: assert property (s.ph == PH_FIN |=> flash_chip_enable_n_o)
    else $error("chip enable not released after auto operation");
  a_buf_low_zero: assert property (buf_addr_o[1:0] == s.lin[1:0])
    else $error("buffer location low bits not zero");
  a_irq_masked: assert property (s.irq_en == 4'h0 |-> !irq_o)
    else $error("interrupt raised with all enables clear");
  a_rb_irq_raise: assert property (rb_edge && n.irq_en[0] |=> irq_o)
    else $error("ready/busy edge did not raise interrupt");
  a_rise_edge: assert property (!s.edge_sel && !s.rb3 && s.rb2 |=> s.pend[NFC_EV_RB])
    else $error("rising ready/busy edge missed");
  a_tight_hold: assert property (s.tight |=> s.tight)
    else $error("lock-tight cleared");
  a_main_freeze: assert property (s.ph == PH_SW && s.main_frz && !wr_init |=> $stable(s.mpar))
    else $error("main parity moved while frozen");
  a_init_clear: assert property (wr_init |=> s.mpar == 16'h0000 && s.spar == 16'h0000)
    else $error("parity not cleared by init");
  a_addr_byte: assert property (flash_ale_o |-> flash_io_o[15:8] == 8'h00)
    else $error("address cycle drives upper lanes");
  a_ce_soft: assert property (s.mode == NFC_MODE_SW && n.mode == NFC_MODE_SW
      && !hw_chip_enable_ctrl_i |=> flash_chip_enable_n_o == s.ce_ctrl)
    else $error("chip enable does not follow control bit");
  c_load_done: cover property (ev[NFC_EV_LOAD]);
  c_store_done: cover property (ev[NFC_EV_STORE]);
  c_sw_read: cover property (s.ph == PH_SW && s.fsm == ST_LO && s.kind == NFC_K_RD);

endmodule : nfc_ctrl_regs
`default_nettype wire

// >>> tb/nfc_flash_model.sv
// Purpose: behavioural flash memory on the far side of the controller
// Assumes: data latched on the rising write strobe while selected
// Notes: a released bus shows the inverse of the next read word, never stale data
`timescale 1ns/100ps
`default_nettype none
module nfc_flash_model #(
  parameter logic [15:0] READ_BASE = 16'h5A3C
)(
  // flash pins
  input wire logic [15:0] io_i,
  input wire logic io_oe_i,
  input wire logic cle_i,
  input wire logic ale_i,
  input wire logic we_n_i,
  input wire logic re_n_i,
  input wire logic ce_n_i,
  // busy request from the bench
  input wire logic busy_i,
  output logic [15:0] io_o,
  output logic rb_o
);
  logic [15:0] rd_q = READ_BASE;
  logic [7:0] last_cmd = 8'h00;
  logic [7:0] last_addr = 8'h00;
  logic [15:0] last_wd = 16'h0000;
  logic slow = 1'b0;
  int n_cmd = 0;
  int n_addr = 0;
  int n_wr = 0;
  // ****
  // latch cycles
  // ****
  // deselected part ignores strobes
  always @(posedge we_n_i)
  begin
    if (!ce_n_i && cle_i)
    begin
      last_cmd = io_i[7:0];
      n_cmd++;
    end
    else if (!ce_n_i && ale_i)
    begin
      last_addr = io_i[7:0];
      n_addr++;
    end
    else if (!ce_n_i)
    begin
      last_wd = io_i;
      n_wr++;
    end
  end
  // second read command makes the part busy for a while, a slow answer
  always @(last_cmd)
  begin
    if (last_cmd == 8'h30)
    begin
      slow = 1'b1;
      #200;
      slow = 1'b0;
    end
  end
  assign rb_o = !(busy_i || slow);
  // read data only while selected and strobed
  assign io_o = (!ce_n_i && !re_n_i && !io_oe_i) ? rd_q : ~rd_q;
  always @(posedge re_n_i)
  begin
    if (!ce_n_i)
      rd_q <= rd_q + 16'h0001;
  end
endmodule : nfc_flash_model
`default_nettype wire

// >>> tb/nfc_ctrl_regs_tb.sv
// Purpose: self-checking bench of the flash controller front end
// Assumes: one ahb-lite master, behavioural flash, short pages
// Notes: page length cut to 4 words to keep automatic runs short
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      n_errors++; \
      $display("BAD %0t line %0d got %h exp %h", $time, `__LINE__, g, e); \
    end \
  end
module nfc_ctrl_regs_tb;
  import nfc_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic hw_ce = 1'b0;
  logic busy = 1'b0;
  wire logic [31:0] hrdata;
  wire logic hready, hresp, oe, cle, ale, we_n, re_n, ce_n, rb, bwe, irq;
  wire logic [15:0] io_o, io_i, bwd, brd;
  wire logic [11:0] baddr;
  int n_errors = 0;
  int check_count = 0;
  int n_ld = 0;
  logic [11:0] ld_first = 12'h000;
  logic [15:0] ld_last = 16'h0000;
  logic [31:0] d;

  nfc_ctrl_regs #(.PAGE_WORDS(4), .ADDR_CYCLES(4)) dut (
    .core_clk_i(core_clk), .reset_i(rst), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .flash_io_o(io_o), .flash_io_oe_o(oe), .flash_io_i(io_i), .flash_cle_o(cle),
    .flash_ale_o(ale), .flash_we_n_o(we_n), .flash_re_n_o(re_n),
    .flash_chip_enable_n_o(ce_n), .ready_busy_input_i(rb),
    .hw_chip_enable_ctrl_i(hw_ce), .buf_addr_o(baddr), .buf_we_o(bwe),
    .buf_wdata_o(bwd), .buf_rdata_i(brd), .irq_o(irq));

  nfc_flash_model fm (
    .io_i(io_o), .io_oe_i(oe), .cle_i(cle), .ale_i(ale), .we_n_i(we_n),
    .re_n_i(re_n), .ce_n_i(ce_n), .busy_i(busy), .io_o(io_i), .rb_o(rb));

  // buffer returns its own word index, so stored data shows its source
  assign brd = {4'h0, baddr};

  always #5 core_clk = ~core_clk;

  always @(posedge core_clk)
  begin
    if (bwe === 1'b1)
    begin
      if (n_ld == 0)
        ld_first <= baddr;
      ld_last <= bwd;
      n_ld <= n_ld + 1;
    end
  end

  // ****
  // bus tasks
  // ****
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rdv);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hready !== 1'b1);
    rdv = hrdata;
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [31:0] wd);
    logic [31:0] x;
    xfer(1'b1, a, wd, x);
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] rdv);
    xfer(1'b0, a, 32'h0, rdv);
  endtask : rd

  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim)
    begin
      @(posedge core_clk);
      n++;
    end
  endtask : wait_irq

  // ****
  // scenarios
  // ****
  task automatic t_reset;
    rd(NFC_CTRL_ADDR, d);
    `CHK(d, 32'h0000_0684)
    `CHK(hresp, 1'b0)
    rd(NFC_CMD_ADDR, d);
    `CHK(d, 32'h0000_0000)
    rd(32'h40C0_0040, d);
    `CHK(d, 32'h0000_0000)
    `CHK(ce_n, 1'b1)
    $display("test reset done");
  endtask : t_reset

  task automatic t_ctrl;
    wr(NFC_CTRL_ADDR, 32'h0FFF_FFFC);
    rd(NFC_CTRL_ADDR, d);
    `CHK(d, 32'h0FFC_FEFC)
    wr(NFC_CTRL_ADDR, 32'h0000_0000);
    rd(NFC_CTRL_ADDR, d);
    `CHK(d, 32'h0000_0008)
    `CHK(ce_n, 1'b0)
    $display("test control done");
  endtask : t_ctrl

  task automatic t_sw;
    wr(NFC_CTRL_ADDR, 32'h0000_0503);
    wr(NFC_CMD_ADDR, 32'h0000_3080);
    `CHK(fm.last_cmd, 8'h80)
    rd(NFC_CMD_ADDR, d);
    `CHK(d, 32'h0000_3080)
    wr(NFC_ADDR_ADDR, 32'hAABB_CCDD);
    `CHK(fm.last_addr, 8'hDD)
    rd(NFC_ADDR_ADDR, d);
    `CHK(d, 32'hAABB_CCDD)
    wr(NFC_DATA_ADDR, 32'h0000_1234);
    `CHK(fm.last_wd, 16'h1234)
    rd(NFC_DATA_ADDR, d);
    `CHK(d, 32'h0000_5A3C)
    rd(NFC_PAR_ADDR, d);
    `CHK(d, 32'h0000_4808)
    wr(NFC_CTRL_ADDR, 32'h0000_0203);
    wr(NFC_DATA_ADDR, 32'h0000_00F0);
    rd(NFC_PAR_ADDR, d);
    `CHK(d, 32'h00F0_4808)
    wr(NFC_CTRL_ADDR, 32'h0000_0683);
    wr(NFC_DATA_ADDR, 32'h0000_FFFF);
    rd(NFC_PAR_ADDR, d);
    `CHK(d, 32'h00F0_4808)
    hw_ce <= 1'b1;
    wr(NFC_CMD_ADDR, 32'h0000_0090);
    `CHK(fm.last_cmd, 8'h90)
    hw_ce <= 1'b0;
    $display("test software done");
  endtask : t_sw

  task automatic t_bad;
    int n;
    wr(NFC_CTRL_ADDR, 32'h0000_8687);
    n = fm.n_wr;
    wr(NFC_DATA_ADDR, 32'h0000_7777);
    wait_irq(8);
    `CHK(irq, 1'b1)
    `CHK(fm.n_wr, n)
    rd(NFC_EVT_ADDR, d);
    `CHK(d, 32'h0000_0008)
    wr(NFC_EVT_ADDR, 32'h0000_0008);
    repeat (2) @(posedge core_clk);
    `CHK(irq, 1'b0)
    wr(NFC_CTRL_ADDR, 32'h0000_0687);
    wr(NFC_DATA_ADDR, 32'h0000_7777);
    repeat (4) @(posedge core_clk);
    `CHK(irq, 1'b0)
    wr(NFC_EVT_ADDR, 32'h0000_000F);
    $display("test bad access done");
  endtask : t_bad

  task automatic t_rb;
    wr(NFC_CTRL_ADDR, 32'h0000_1683);
    busy <= 1'b1;
    repeat (8) @(posedge core_clk);
    `CHK(irq, 1'b0)
    busy <= 1'b0;
    wait_irq(8);
    `CHK(irq, 1'b1)
    wr(NFC_EVT_ADDR, 32'h0000_0001);
    repeat (2) @(posedge core_clk);
    `CHK(irq, 1'b0)
    wr(NFC_CTRL_ADDR, 32'h0000_1E83);
    busy <= 1'b1;
    wait_irq(8);
    `CHK(irq, 1'b1)
    wr(NFC_EVT_ADDR, 32'h0000_0001);
    wr(NFC_CTRL_ADDR, 32'h0000_0E83);
    busy <= 1'b0;
    repeat (8) @(posedge core_clk);
    busy <= 1'b1;
    repeat (8) @(posedge core_clk);
    `CHK(irq, 1'b0)
    busy <= 1'b0;
    repeat (8) @(posedge core_clk);
    wr(NFC_EVT_ADDR, 32'h0000_000F);
    $display("test ready busy done");
  endtask : t_rb

  task automatic t_load;
    int c;
    int a;
    wr(NFC_CTRL_ADDR, 32'h0000_0680);
    wr(NFC_CMD_ADDR, 32'h0000_3000);
    wr(NFC_ADDR_ADDR, 32'h0003_0201);
    c = fm.n_cmd;
    a = fm.n_addr;
    wr(NFC_CTRL_ADDR, 32'h0040_4691);
    wait_irq(3000);
    `CHK(irq, 1'b1)
    `CHK(n_ld, 8)
    `CHK(ld_last, 16'h5A44)
    `CHK(ld_first, 12'h040)
    `CHK(fm.last_cmd, 8'h30)
    `CHK(fm.n_cmd - c, 2)
    `CHK(fm.n_addr - a, 4)
    `CHK(ce_n, 1'b1)
    rd(NFC_CTRL_ADDR, d);
    `CHK(d[7], 1'b1)
    `CHK(d[1:0], 2'h1)
    wr(NFC_CTRL_ADDR, 32'h0000_0680);
    wr(NFC_EVT_ADDR, 32'h0000_000F);
    $display("test auto load done");
  endtask : t_load

  task automatic t_store;
    int w;
    w = fm.n_wr;
    wr(NFC_CTRL_ADDR, 32'h0040_2692);
    wait_irq(3000);
    `CHK(irq, 1'b1)
    `CHK(fm.n_wr - w, 4)
    `CHK(fm.last_wd, 16'h0043)
    `CHK(ce_n, 1'b1)
    wr(NFC_CTRL_ADDR, 32'h0000_0680);
    wr(NFC_EVT_ADDR, 32'h0000_000F);
    $display("test auto store done");
  endtask : t_store

  // ****
  // run control
  // ****
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  initial
  begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_ctrl();
    t_sw();
    t_bad();
    t_rb();
    t_load();
    t_store();
    stop_test();
  end

  // all tests take a few hundred cycles; this bound only cuts a hang
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    stop_test();
  end
endmodule : nfc_ctrl_regs_tb
`default_nettype wire
